/* brownout_reset_pkg.sv */
package brownout_reset_pkg;

	// Register word addresses; a register's byte address is four times this.
	localparam logic [7:0] STATUS_IDX      = 8'h03;
	localparam logic [7:0] PWRCTL_IDX      = 8'h8E;
	localparam logic [7:0] CFG_IDX         = 8'hC0;
	localparam logic [7:0] CAUSE_IDX       = 8'hC1;

	// Bit positions.
	localparam int BOR_BIT                 = 0;
	localparam int POR_BIT                 = 1;
	localparam int SLEEP_BIT               = 3;
	localparam int TIMEOUT_BIT             = 4;

	// Configuration word layout.
	localparam int CFG_MODE_LO             = 0;
	localparam int CFG_POWERUP_TIMER_DIS_BIT        = 2;
	localparam int CFG_EXTCLK_BIT          = 3;
	localparam logic [3:0] CFG_RESET       = 4'hF;

	// Brown-out modes.
	localparam logic [1:0] BOR_MODE_OFF    = 2'h0;
	localparam logic [1:0] BOR_MODE_SLEEP  = 2'h2;

	// Timing.
	localparam int CLK_MHZ                 = 100;
	localparam int POWERUP_TIMER_MS                 = 64;
	localparam int RC_KHZ                  = 31;
	localparam int POWERUP_TIMER_TICKS              = POWERUP_TIMER_MS * RC_KHZ;
	localparam int RC_DIV                  = (CLK_MHZ * 1000) / RC_KHZ;
	localparam int BOR_QUAL_US             = 2;
	localparam int BOR_QUAL_CYC            = BOR_QUAL_US * CLK_MHZ;
	localparam int OST_TICKS               = 1024;

	// Reset class enumeration.
	typedef enum logic [2:0]
	{
		CAUSE_NONE    = 3'b000,
		CAUSE_POR     = 3'b001,
		CAUSE_BOR     = 3'b010,
		CAUSE_WDT     = 3'b011,
		CAUSE_WDTWAKE = 3'b100,
		CAUSE_EXTRUN  = 3'b101,
		CAUSE_EXTSLP  = 3'b110
	} cause_t;

	typedef enum logic [2:0]
	{
		SEQ_POR  = 3'b000,
		SEQ_SUP  = 3'b001,
		SEQ_POWERUP_TIMER = 3'b010,
		SEQ_OST  = 3'b011,
		SEQ_PIN  = 3'b100,
		SEQ_RUN  = 3'b101
	} seq_t;

endpackage

/* rc_tick_counter.sv */
`timescale 1ns/1ps
module rc_tick_counter
#(
	parameter int TICKS = 16
)
(
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst_b,
	// Control.
	input  wire logic clear,
	input  wire logic tick,
	// Result.
	output logic      done
);
	localparam int W = $clog2(TICKS + 1);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	wire          atEnd = (count_reg == W'(TICKS));

	// Counts ticks of the slow RC clock, not mclk cycles.
	assign count_next = clear ? '0 : ((tick && !atEnd) ? count_reg + 1'b1
		: count_reg);
	assign done = atEnd && !clear;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end
endmodule

/* brownout_reset_sequencer.sv */
// Operation
// R1 - Two-bit mode picks brown-out behaviour; mode 10 disables detector during sleep.
// R2 - Mode 00 turns detector off; brown-out flag then carries no meaning.
// R3 - Reset only after low supply persists beyond the qualification time.
// R4 - After any reset, core stays in reset while supply is low.
// R5 - Enabled power-up timer adds 64 ms reset after supply clears.
// R6 - One configuration bit enables or disables the power-up timer.
// R7 - That bit is active low: set disables, cleared enables the timer.
// R8 - Supply dip during power-up timer re-enters reset and restarts full time.
// R9 - Power-up timer starts after power-on; start-up timer after power-up timer.
// R10 - External clock with timer disabled gives no time-out at all.
// R11 - Time-outs run regardless of pin; late pin release starts at once.
// R12 - Power-control register at 8Eh holds only two cause flags.
// R13 - Bit 0 brown-out flag: cleared by brown-out, set by software.
// R14 - Bit 1 power-on flag: cleared at power-on only, set by software.
// R15 - Unimplemented bits read zero and ignore writes.
// R16 - Core flags: bit 4 time-out flag, bit 3 sleep-entry flag.
// R17 - Time-out and sleep flags follow the reset class.
// R18 - Watchdog wake-up resumes operation without a register reset.
// R19 - All sources merge into one reset held until every condition clears.
// R20 - Power-up time-out counts ticks of the internal RC clock.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
module brownout_reset_sequencer
	import brownout_reset_pkg::*;
#(
	parameter int POWERUP_TIMER_COUNT = brownout_reset_pkg::POWERUP_TIMER_TICKS,
	parameter int RC_DIVIDE  = brownout_reset_pkg::RC_DIV,
	parameter int OST_COUNT  = brownout_reset_pkg::OST_TICKS,
	parameter int QUAL_COUNT = brownout_reset_pkg::BOR_QUAL_CYC
)
(
	// Clock and power-on reset.
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Analog side and pins.
	input  wire logic        supplyLow,
	input  wire logic        external_reset_pin_b,
	input  wire logic        watchdogTimeout,
	input  wire logic        sleepActive,
	// Core side.
	output logic             coreReset,
	output logic             brownoutEnable,
	output logic             warmReset,
	// Avalon-MM slave.
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic [1:0]       avs_response
);
	import brownout_reset_pkg::*;

	localparam int QW = $clog2(QUAL_COUNT + 1);
	localparam int DW = $clog2(RC_DIVIDE + 1);

	seq_t         state_reg;
	seq_t         state_next;
	cause_t       cause_reg;
	logic [3:0]   cfg_reg;
	logic [1:0]   pwrctl_reg;
	logic         timeout_reg;
	logic         sleep_reg;
	logic [QW-1:0] qual_reg;
	logic [DW-1:0] div_reg;
	logic [31:0]  readdata_reg;
	logic         ack_reg;

	// Decoding of configuration.
	wire [1:0] borMode   = cfg_reg[CFG_MODE_LO +: 2];
	wire       pwrtDis   = cfg_reg[CFG_POWERUP_TIMER_DIS_BIT];
	wire       extClock  = cfg_reg[CFG_EXTCLK_BIT];
	wire       pwrtOn    = !pwrtDis; // see R7
	// Detector off in mode 00, and off in sleep for mode 10.
	wire       borActive = (borMode != BOR_MODE_OFF) &&
		!((borMode == BOR_MODE_SLEEP) && sleepActive); // see R1
	wire       lowSeen   = borActive && supplyLow;

	// Qualification filter ignores short dips of the supply.
	wire       brownout  = lowSeen && (qual_reg == QW'(QUAL_COUNT)); // see R3
	wire [QW-1:0] qualNext = !lowSeen ? '0 :
		(brownout ? qual_reg : qual_reg + 1'b1);

	// Divider forms the internal RC clock tick.
	wire       rcTick    = (div_reg == DW'(RC_DIVIDE - 1)); // see R20
	wire [DW-1:0] divNext = rcTick ? '0 : div_reg + 1'b1;

	wire       pwrtDone;
	wire       ostDone;
	wire       supplyOk  = !(borActive && supplyLow); // see R4
	wire       pinLow    = !external_reset_pin_b;

	// A brown-out during the power-up timer clears it back to start.
	rc_tick_counter #(.TICKS(POWERUP_TIMER_COUNT)) pwrtCounter
	(
		.mclk  (mclk),
		.rst_b (rst_b),
		.clear (state_reg != SEQ_POWERUP_TIMER), // see R8
		.tick  (rcTick),
		.done  (pwrtDone)
	);

	rc_tick_counter #(.TICKS(OST_COUNT)) ostCounter
	(
		.mclk  (mclk),
		.rst_b (rst_b),
		.clear (state_reg != SEQ_OST),
		.tick  (rcTick),
		.done  (ostDone)
	);

	// Time-out sequence; the pin is checked only after the timers.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			SEQ_POR:
				state_next = SEQ_SUP; // see R9
			SEQ_SUP:
				if (supplyOk)
				begin
					if (pwrtOn)
						state_next = SEQ_POWERUP_TIMER; // see R5
					else if (extClock)
						state_next = SEQ_PIN; // see R10
					else
						state_next = SEQ_OST;
				end
			SEQ_POWERUP_TIMER:
				if (!supplyOk)
					state_next = SEQ_SUP; // see R8
				else if (pwrtDone)
					state_next = extClock ? SEQ_PIN : SEQ_OST; // see R9
			SEQ_OST:
				if (!supplyOk)
					state_next = SEQ_SUP;
				else if (ostDone)
					state_next = SEQ_PIN;
			SEQ_PIN:
				if (!supplyOk)
					state_next = SEQ_SUP;
				else if (!pinLow)
					state_next = SEQ_RUN; // see R11
			SEQ_RUN:
				if (brownout)
					state_next = SEQ_SUP; // see R4
				else if (watchdogTimeout && !sleepActive)
					state_next = SEQ_SUP;
				else if (pinLow)
					state_next = SEQ_PIN; // see R11
			default:
				state_next = SEQ_POR;
		endcase
	end

	// Classify the event seen in the running state.
	wire    runExit   = (state_reg == SEQ_RUN);
	wire    wdtWake   = runExit && watchdogTimeout && sleepActive;
	cause_t newCause;
	assign newCause = !runExit ? CAUSE_NONE :
		brownout ? CAUSE_BOR :
		(watchdogTimeout && !sleepActive) ? CAUSE_WDT :
		wdtWake ? CAUSE_WDTWAKE :
		(pinLow && sleepActive) ? CAUSE_EXTSLP :
		pinLow ? CAUSE_EXTRUN : CAUSE_NONE;

	// Bus decode; one cycle of wait on every access.
	wire [7:0] wordIdx = avs_address[9:2];
	wire       access  = (avs_read || avs_write) && !ack_reg;
	wire       hitSt   = (wordIdx == STATUS_IDX);
	wire       hitPc   = (wordIdx == PWRCTL_IDX);
	wire       hitCfg  = (wordIdx == CFG_IDX);
	wire       hitCs   = (wordIdx == CAUSE_IDX);
	wire       mapped  = hitSt || hitPc || hitCfg || hitCs;
	wire       wrLow   = avs_write && access && avs_byteenable[0];
	wire       wrPc    = wrLow && hitPc && !coreReset;
	wire       wrCfg   = wrLow && hitCfg;
	// Each register returns only its implemented bits; all other bits read zero.
	wire [31:0] rdMux  =
		hitSt ? {27'h0, timeout_reg, sleep_reg, 3'h0} : // see R16
		hitPc ? {30'h0, pwrctl_reg} : // see R12 R15
		hitCfg ? {28'h0, cfg_reg} :
		hitCs ? {29'h0, cause_reg} : 32'h0;

	// Flags per reset class; a hardware clear wins over a software set.
	wire porEvt = (state_reg == SEQ_POR);
	wire borEvt = (newCause == CAUSE_BOR);
	wire [1:0] pcNext;
	assign pcNext[POR_BIT] = porEvt ? 1'b0 : // see R14
		(wrPc ? avs_writedata[POR_BIT] : pwrctl_reg[POR_BIT]);
	assign pcNext[BOR_BIT] = borEvt ? 1'b0 : // see R13 R2
		(wrPc ? avs_writedata[BOR_BIT] : pwrctl_reg[BOR_BIT]);

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg    <= SEQ_POR;
			cause_reg    <= CAUSE_POR;
			cfg_reg      <= CFG_RESET;
			pwrctl_reg   <= 2'h0;
			timeout_reg  <= 1'b1;
			sleep_reg    <= 1'b1;
			qual_reg     <= '0;
			div_reg      <= '0;
			readdata_reg <= 32'h0;
			ack_reg      <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next; // see R19
			qual_reg     <= qualNext;
			div_reg      <= divNext;
			pwrctl_reg   <= pcNext;
			ack_reg      <= access;
			if (access && avs_read)
				readdata_reg <= rdMux;
			if (wrCfg)
				cfg_reg <= avs_writedata[3:0];
			if (newCause != CAUSE_NONE)
				cause_reg <= newCause;
			// Time-out and sleep flags per reset class.
			case (newCause)
				CAUSE_BOR:
				begin
					timeout_reg <= 1'b1; // see R17
					sleep_reg   <= 1'b1;
				end
				CAUSE_WDT:
					timeout_reg <= 1'b0;
				CAUSE_WDTWAKE:
				begin
					timeout_reg <= 1'b0; // see R18
					sleep_reg   <= 1'b0;
				end
				CAUSE_EXTSLP:
				begin
					timeout_reg <= 1'b1;
					sleep_reg   <= 1'b0;
				end
				default:
				begin
					timeout_reg <= timeout_reg;
					sleep_reg   <= sleep_reg;
				end
			endcase
		end
	end

	// Core held in reset until every stage has passed.
	assign coreReset       = (state_reg != SEQ_RUN); // see R19
	assign warmReset       = coreReset && (cause_reg != CAUSE_POR);
	assign brownoutEnable  = borActive;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign avs_readdata    = readdata_reg;
	// Unmapped addresses answer with a decode error and zero data.
	assign avs_response    = mapped ? 2'h0 : 2'h3;
endmodule

/* brownout_reset_sequencer_properties.sv */
`timescale 1ns/1ps
module brownout_reset_sequencer_properties
	import brownout_reset_pkg::*;
#(
	parameter int QUAL_COUNT = 3
)
(
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        rst_b,
	// Supply, pin and core.
	input wire logic        supplyLow,
	input wire logic        external_reset_pin_b,
	input wire logic        watchdogTimeout,
	input wire logic        coreReset,
	input wire logic        brownoutEnable,
	// Register bus.
	input wire logic [9:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response
);
	wire [7:0]   idx    = avs_address[9:2];
	wire         anyReq = avs_read || avs_write;
	wire         ack    = avs_read && !avs_waitrequest;
	wire         mapped = idx == STATUS_IDX || idx == PWRCTL_IDX
		|| idx == CFG_IDX || idx == CAUSE_IDX;
	logic [15:0] lowCnt;
	// A counter keeps long low spans out of unrolled repetitions.
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			lowCnt <= 16'h0000;
		else if (supplyLow && brownoutEnable)
			lowCnt <= lowCnt + 16'h0001;
		else
			lowCnt <= 16'h0000;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_req_rise;
		anyReq && !$past(anyReq);
	endsequence
	sequence s_ack_next;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	a_ack_one_cycle: assert property (s_req_rise |-> s_ack_next)
		else $error("Bus answer not one cycle after request.");
	a_unmapped_resp: assert property (anyReq && !mapped |-> avs_response == 2'h3)
		else $error("Unmapped access not refused.");
	a_mapped_okay: assert property (anyReq && mapped |-> avs_response == 2'h0)
		else $error("Mapped access refused.");
	a_unmapped_zero: assert property (ack && !mapped |=> avs_readdata == 32'h0)
		else $error("Unmapped read not zero.");
	a_pwr_high_zero: assert property (ack && idx == PWRCTL_IDX
		|=> avs_readdata[31:2] == 30'h0)
		else $error("Power flags upper bits not zero.");
	a_qual_hold: assert property (lowCnt > QUAL_COUNT + 1 |-> coreReset)
		else $error("Long low supply did not hold reset.");
	a_short_dip: assert property (!coreReset && lowCnt == 16'h0001
		&& external_reset_pin_b && !watchdogTimeout |=> !coreReset)
		else $error("Short dip caused reset.");
	a_pin_hold: assert property (!external_reset_pin_b [*2] |-> coreReset)
		else $error("Pin low did not hold reset.");
endmodule
bind brownout_reset_sequencer brownout_reset_sequencer_properties
	#(.QUAL_COUNT(QUAL_COUNT)) i_brownout_reset_sequencer_properties
	(.mclk, .rst_b, .supplyLow, .external_reset_pin_b, .watchdogTimeout,
	.coreReset, .brownoutEnable, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .avs_response);

/* supply_rail_model.sv */
`timescale 1ns/1ps
module supply_rail_model
(
	// Clock.
	input  wire logic        mclk,
	// Commands.
	input  wire logic        dipGo,
	input  wire logic [11:0] dipLen,
	input  wire logic        pinHold,
	// Comparator and pin.
	output logic             supplyLow,
	output logic             pinOut_b
);
	logic [11:0] leftReg = 12'h000;
	always_ff @(posedge mclk)
		leftReg <= dipGo ? dipLen : leftReg - 12'(leftReg != 12'h000);
	assign supplyLow = leftReg != 12'h000;
	// The pin is held low by the outside party for as long as asked.
	assign pinOut_b = !pinHold;
endmodule

/* brownout_reset_sequencer_test.sv */
`timescale 1ns/1ps
module brownout_reset_sequencer_test;
	import brownout_reset_pkg::*;
	logic        mclk = 1'b0, rst_b = 1'b0, wdt = 1'b0, sleepOn = 1'b0;
	logic        pinHold = 1'b0, dipGo = 1'b0, avRead = 1'b0, avWrite = 1'b0;
	logic [11:0] dipLen = 12'h000;
	logic [9:0]  avAddr = 10'h000;
	logic [31:0] avWdata = 32'h0, avRdata, rdat;
	logic [1:0]  avResp, rrsp;
	logic        avWait, coreReset, bodEn, supplyLow, pinB, hit;
	int          fails = 0, checks = 0, n;
	logic [4:0]  tbl [4] = '{5'h0D, 5'h15, 5'h10, 5'h1A};
	initial
		forever #5 mclk = ~mclk;
	supply_rail_model i_supply_rail_model (.mclk, .dipGo, .dipLen,
		.pinHold, .supplyLow, .pinOut_b(pinB));
	brownout_reset_sequencer #(.POWERUP_TIMER_COUNT(4), .RC_DIVIDE(4), .OST_COUNT(2),
		.QUAL_COUNT(3)) i_brownout_reset_sequencer (.mclk, .rst_b,
		.supplyLow, .external_reset_pin_b(pinB), .watchdogTimeout(wdt),
		.sleepActive(sleepOn), .coreReset, .brownoutEnable(bodEn),
		.warmReset(), .avs_address(avAddr), .avs_read(avRead),
		.avs_write(avWrite), .avs_writedata(avWdata),
		.avs_byteenable(4'hF), .avs_readdata(avRdata),
		.avs_waitrequest(avWait), .avs_response(avResp));
	function automatic logic bodExp(input logic [1:0] m, input logic s);
		return m != BOR_MODE_OFF && !(m == BOR_MODE_SLEEP && s);
	endfunction
	task automatic check(input logic [33:0] seen, exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		avAddr <= {idx, 2'h0};
		avWdata <= d;
		avRead <= !w;
		avWrite <= w;
		do @(posedge mclk); while (avWait !== 1'b0);
		rdat = avRdata;
		rrsp = avResp;
		avRead <= 1'b0;
		avWrite <= 1'b0;
		@(posedge mclk);
	endtask
	// One edge always passes first, so a reset launched at the edge that
	// called us is seen before the core is judged to be running.
	task automatic waitCore(output int c);
		c = 0;
		do
		begin
			@(posedge mclk);
			c++;
		end
		while (coreReset !== 1'b0);
	endtask
	task automatic dip(input logic [11:0] len);
		dipLen <= len;
		dipGo <= 1'b1;
		@(posedge mclk);
		dipGo <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge mclk);
		fails++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(32'h847de03b));
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		waitCore(n);
		check(n < 8, 1, "fast release");
		bus(1'b0, PWRCTL_IDX, 32'h0);
		check(rdat, 32'h0, "power flags");
		bus(1'b0, STATUS_IDX, 32'h0);
		check(rdat[4:3], 2'h3, "status flags");
		bus(1'b1, PWRCTL_IDX, $urandom | 32'h3);
		bus(1'b0, PWRCTL_IDX, 32'h0);
		check(rdat, 32'h3, "power write");
		bus(1'b0, 8'h10 + 8'($urandom % 112), 32'h0);
		check({rrsp, rdat}, 34'h300000000, "unmapped");
		for (int m = 0; m < 8; m++)
		begin
			sleepOn <= m[2];
			bus(1'b1, CFG_IDX, {30'h3, m[1:0]});
			check(bodEn, bodExp(m[1:0], m[2]), "detector");
		end
		$display("test registers done");
		sleepOn <= 1'b0;
		bus(1'b1, CFG_IDX, 32'h1);
		dip(12'h028);
		while (supplyLow) @(posedge mclk);
		repeat (6) @(posedge mclk);
		check(coreReset, 1'b1, "timer hold");
		dip(12'h014);
		while (supplyLow) @(posedge mclk);
		waitCore(n);
		check(n >= 16 && n < 48, 1, "timer length");
		bus(1'b0, PWRCTL_IDX, 32'h0);
		check(rdat, 32'h2, "after brown-out");
		bus(1'b0, CAUSE_IDX, 32'h0);
		check(rdat[2:0], CAUSE_BOR, "cause");
		bus(1'b1, PWRCTL_IDX, 32'h3);
		dip(12'h001 + 12'($urandom % 2));
		hit = 1'b0;
		repeat (8)
		begin
			@(posedge mclk);
			hit |= coreReset;
		end
		check(hit, 1'b0, "short dip");
		$display("test brown-out done");
		pinHold <= 1'b1;
		dip(12'h028);
		repeat (120) @(posedge mclk);
		pinHold <= 1'b0;
		waitCore(n);
		check(n < 4, 1, "late pin");
		bus(1'b1, PWRCTL_IDX, 32'h3);
		for (int k = 0; k < 4; k++)
		begin
			sleepOn <= k[1];
			@(posedge mclk);
			wdt <= !k[0];
			pinHold <= k[0];
			@(posedge mclk);
			wdt <= 1'b0;
			pinHold <= 1'b0;
			sleepOn <= 1'b0;
			waitCore(n);
			bus(1'b0, CAUSE_IDX, 32'h0);
			check(rdat[2:0], tbl[k][4:2], "class");
			bus(1'b0, STATUS_IDX, 32'h0);
			check(rdat[4:3], tbl[k][1:0], "class flags");
			bus(1'b0, PWRCTL_IDX, 32'h0);
			check(rdat, 32'h3, "flags kept");
		end
		$display("test reset classes done");
		end_of_test();
	end
endmodule
